// [hw/fbp_regs.svh]
// Notes on behaviour
// - controller chip registers at ports 64..67
// - low address byte decoded, match gates strobes
// - transfers qualified by write/dbin/sout/sinp lines
// - wait states only on sector data port, or on a write to any controller port while the write buffer is full
// - ready held low until controller ready
// - control bit 7 enables wait states
// - port 63 control register, bits 0-3 select drives
// - bit 4 side select, bit 5 drive size
// - bit 6 drives density select
// - port 63 input returns control register
// - data-in buffer enabled only during board reads
// - controller bytes toward cpu are inverted, control readback is not
// - outbound buffer enabled except board reads
// - bytes from cpu to the controller are inverted, control register writes are not
// - optional interrupt on operation completion
// - early/late precompensation at double density
// - read data split into data and clock
// - all timing from one crystal clock
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH
`define FBP_PORT_CTRL      8'h63
`define FBP_PORT_FDC_BASE  8'h64
`define FBP_PORT_FDC_DATA  2'h3
`define FBP_CTRL_RESET     8'h00
`define FBP_BIT_SIDE       4
`define FBP_BIT_SIZE8      5
`define FBP_BIT_DDEN       6
`define FBP_BIT_WAIT       7
`define FBP_CLK_NS         8
`define FBP_STB_NS         200
`define FBP_STB_CYC        ((`FBP_STB_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS)
`define FBP_FDC_CLK_NS     500
`define FBP_FDC_HALF_CYC   ((`FBP_FDC_CLK_NS / 2) / `FBP_CLK_NS)
`define FBP_CELL_NS        4000
`define FBP_CELL_CYC       (`FBP_CELL_NS / `FBP_CLK_NS)
`endif

// [hw/fbp_pkg.sv]
package fbp_pkg;
  // one queued write toward the controller chip
  typedef struct packed {
    logic [1:0] a;    // controller register select
    logic [7:0] d;    // byte as the cpu wrote it
    logic       wt;   // sector data write that must wait
  } fbp_wr_t;
  // control register fields
  typedef struct packed {
    logic       wait_en;
    logic       dden;
    logic       size8;
    logic       side;
    logic [3:0] sel;
  } fbp_ctrl_t;
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_STB, R_HOLD} fbp_rd_st_t;
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_STB} fbp_dr_st_t;
endpackage

// [hw/fbp_fifo.sv]
`timescale 1ns/10ps
module fbp_fifo
  import fbp_pkg::*;
#(
  parameter int W     = 11,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];   // entry storage
  logic [AW-1:0] wp_q;           // write pointer
  logic [AW-1:0] rp_q;           // read pointer
  logic [AW:0]   cnt_q;          // occupancy
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];

  // pointer wrap helper
  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // storage needs no reset, only pointers and count do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= inc(wp_q);
      if (pop) rp_q <= inc(rp_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [hw/fbp_glue.sv]
`timescale 1ns/10ps
`include "fbp_regs.svh"
module fbp_glue
  import fbp_pkg::*;
#(
  parameter int STB_CYC  = `FBP_STB_CYC,
  parameter int HALF_CYC = `FBP_FDC_HALF_CYC,
  parameter int CELL_CYC = `FBP_CELL_CYC
) (
  // clock and synchronous reset (power-on clear)
  input  wire logic       clk,
  input  wire logic       resetn,
  // cpu bus side
  input  wire logic [7:0] addr,
  input  wire logic [7:0] cpu_dout,
  input  wire logic       sout,
  input  wire logic       sinp,
  input  wire logic       pwr_n,
  input  wire logic       pdbin,
  output logic [7:0]      cpu_din_q,
  output logic            din_en_q,
  output logic            prdy_q,
  output logic            irq_q,
  input  wire logic       int_en,
  // controller chip side
  input  wire logic [7:0] fdc_d_i,
  output logic [7:0]      fdc_d_o_q,
  output logic            fdc_d_oe_n_q,
  output logic            fdc_cs_n_q,
  output logic            fdc_re_n_q,
  output logic            fdc_we_n_q,
  output logic [1:0]      fdc_a_q,
  input  wire logic       fdc_drq,
  input  wire logic       fdc_busy,
  input  wire logic       fdc_intrq,
  input  wire logic       fdc_early,
  input  wire logic       fdc_late,
  output logic            fdc_clk_q,
  output logic            fdc_dden_q,
  output logic            sep_data_q,
  output logic            sep_clk_q,
  output logic            pre_early_q,
  output logic            pre_late_q,
  // drive side
  output logic [3:0]      drv_sel_q,
  output logic            side_sel_q,
  output logic            size8_q,
  input  wire logic       rd_raw_n
);
  localparam logic [7:0] FDC_BASE = `FBP_PORT_FDC_BASE;
  localparam int SW = $clog2(STB_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int CW = $clog2(2 * CELL_CYC + 1);

  fbp_ctrl_t  ctrl_q, ctrl_d;   // drive control register
  fbp_rd_st_t rd_st_q, rd_st_d; // read sequencer
  fbp_dr_st_t dr_st_q, dr_st_d; // write drain sequencer
  logic [SW-1:0] stb_q;         // strobe width counter
  logic wr_done_q;              // current write cycle already taken
  logic wr_hold_q;              // waited write still in the buffer
  logic [HW-1:0] div_q;         // controller clock divider
  logic [CW-1:0] cell_q;        // separator cell timer
  logic raw_q;                  // previous read data level
  fbp_wr_t wr_in, wr_out;       // buffer words
  logic in_ready, out_valid, pop;

  wire hit_ctrl  = (addr == `FBP_PORT_CTRL);
  wire hit_fdc   = (addr[7:2] == FDC_BASE[7:2]);
  wire hit_board = hit_ctrl || hit_fdc;
  wire hit_data  = hit_fdc && (addr[1:0] == `FBP_PORT_FDC_DATA);
  wire wr_cyc    = sout && !pwr_n;
  wire rd_cyc    = sinp && pdbin;
  wire wr_new    = wr_cyc && hit_board && !wr_done_q;
  wire push      = wr_new && hit_fdc && in_ready;
  wire push_wt   = push && hit_data && ctrl_q.wait_en;
  // release on request or idle chip
  wire fdc_go    = fdc_drq || !fdc_busy;
  wire stb_end   = (stb_q == SW'(STB_CYC - 1));
  wire rd_start  = rd_cyc && hit_fdc && (rd_st_q == R_IDLE) && !out_valid
                   && (dr_st_q == D_IDLE);
  int  cell_n;                  // cycles per bit cell for the selected drive
  assign cell_n = cell_len(ctrl_q.size8, ctrl_q.dden);
  wire cell_half = (cell_q >= CW'(cell_n / 4)) && (cell_q < CW'(3 * cell_n / 4));
  wire raw_fall  = raw_q && !rd_raw_n;

  assign wr_in = '{a: addr[1:0], d: cpu_dout, wt: hit_data && ctrl_q.wait_en};
  assign pop   = (dr_st_q == D_STB) && stb_end;

  // cell length follows density and drive size
  // fields come in as arguments so the wire above follows every register change
  function automatic int cell_len(input logic size8, input logic dden);
    cell_len = size8 ? CELL_CYC : 2 * CELL_CYC;
    if (dden) cell_len = cell_len / 2;
  endfunction

  // two-entry buffer lets a controller stall without losing writes
  fbp_fifo #(.W($bits(fbp_wr_t)), .DEPTH(2)) u_wbuf (
    .clk      (clk),
    .resetn   (resetn),
    .in_valid (wr_new && hit_fdc),
    .in_ready (in_ready),
    .in_data  (wr_in),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data (wr_out)
  );

  // control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_new && hit_ctrl) begin
      ctrl_d = fbp_ctrl_t'(cpu_dout);
    end
  end

  // read sequencer; waits for the write buffer so order is kept
  always_comb begin
    rd_st_d = rd_st_q;
    case (rd_st_q)
      R_IDLE: begin
        if (rd_cyc && hit_ctrl) begin
          rd_st_d = R_HOLD;
        end else if (rd_start) begin
          rd_st_d = (hit_data && ctrl_q.wait_en) ? R_WAIT : R_STB;
        end
      end
      R_WAIT:  if (fdc_go) rd_st_d = R_STB;
      R_STB:   if (stb_end) rd_st_d = R_HOLD;
      R_HOLD:  if (!rd_cyc) rd_st_d = R_IDLE;
      default: rd_st_d = R_IDLE;
    endcase
  end

  // drain sequencer, kept off while a read owns the internal bus
  always_comb begin
    dr_st_d = dr_st_q;
    case (dr_st_q)
      D_IDLE: begin
        if (out_valid && rd_st_q == R_IDLE && !rd_cyc) begin
          dr_st_d = wr_out.wt ? D_WAIT : D_STB;
        end
      end
      D_WAIT:  if (fdc_go) dr_st_d = D_STB;
      D_STB:   if (stb_end) dr_st_d = D_IDLE;
      default: dr_st_d = D_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) ctrl_q <= fbp_ctrl_t'(`FBP_CTRL_RESET);
    else ctrl_q <= ctrl_d;
  end

  // sequencer states and strobe counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_st_q <= R_IDLE;
      dr_st_q <= D_IDLE;
      stb_q   <= '0;
    end else begin
      rd_st_q <= rd_st_d;
      dr_st_q <= dr_st_d;
      stb_q   <= (rd_st_q == R_STB || dr_st_q == D_STB) && !stb_end ? stb_q + SW'(1) : '0;
    end
  end

  // write cycle bookkeeping; hold is set only, cleared when its word leaves
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_done_q <= 1'b0;
      wr_hold_q <= 1'b0;
    end else begin
      wr_done_q <= wr_cyc && (wr_done_q || (wr_new && (hit_ctrl || in_ready)));
      if (push_wt) wr_hold_q <= 1'b1;
      else if (pop && wr_out.wt) wr_hold_q <= 1'b0;
    end
  end

  // ready: low while a write waits for room, a waited write drains,
  // or a waited sector read has no byte yet; other reads never wait
  always_ff @(posedge clk) begin
    if (!resetn) prdy_q <= 1'b1;
    else prdy_q <= !((wr_new && hit_fdc && !in_ready) || push_wt || wr_hold_q
                     || (rd_cyc && hit_data && ctrl_q.wait_en && rd_st_q != R_HOLD));
  end

  // cpu data-in path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_din_q <= '0;
      din_en_q  <= 1'b0;
    end else begin
      if (rd_st_q == R_IDLE && rd_cyc && hit_ctrl) cpu_din_q <= ctrl_q;
      else if (rd_st_q == R_STB && stb_end) cpu_din_q <= ~fdc_d_i;
      din_en_q <= (rd_st_d == R_HOLD) && rd_cyc;
    end
  end

  // controller strobes and internal bus
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fdc_cs_n_q   <= 1'b1;
      fdc_re_n_q   <= 1'b1;
      fdc_we_n_q   <= 1'b1;
      fdc_a_q      <= '0;
      fdc_d_o_q    <= 8'hff;
      fdc_d_oe_n_q <= 1'b0;
    end else begin
      fdc_re_n_q <= !(rd_st_d == R_STB);
      fdc_we_n_q <= !(dr_st_d == D_STB);
      fdc_cs_n_q <= !(rd_st_d == R_STB || dr_st_d == D_STB);
      fdc_a_q    <= (rd_st_d == R_STB) ? addr[1:0] : wr_out.a;
      fdc_d_o_q  <= ~wr_out.d;
      fdc_d_oe_n_q <= rd_cyc && hit_board;
    end
  end

  // drive outputs and option outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      drv_sel_q   <= '0;
      side_sel_q  <= 1'b0;
      size8_q     <= 1'b0;
      fdc_dden_q  <= 1'b0;
      irq_q       <= 1'b0;
      pre_early_q <= 1'b0;
      pre_late_q  <= 1'b0;
    end else begin
      drv_sel_q   <= ctrl_q.sel;
      side_sel_q  <= ctrl_q.side;
      size8_q     <= ctrl_q.size8;
      fdc_dden_q  <= ctrl_q.dden;
      irq_q       <= int_en && fdc_intrq;
      pre_early_q <= ctrl_q.dden && fdc_early;
      pre_late_q  <= ctrl_q.dden && fdc_late;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q     <= '0;
      fdc_clk_q <= 1'b0;
    end else if (div_q == HW'(HALF_CYC - 1)) begin
      div_q     <= '0;
      fdc_clk_q <= !fdc_clk_q;
    end else begin
      div_q <= div_q + HW'(1);
    end
  end

  // mid-cell pulses are data, others realign the clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      raw_q      <= 1'b1;
      cell_q     <= '0;
      sep_data_q <= 1'b0;
      sep_clk_q  <= 1'b0;
    end else begin
      raw_q      <= rd_raw_n;
      sep_data_q <= raw_fall && cell_half;
      sep_clk_q  <= raw_fall && !cell_half;
      if (raw_fall && !cell_half) cell_q <= '0;
      else if (cell_q >= CW'(cell_n - 1)) cell_q <= '0;
      else cell_q <= cell_q + CW'(1);
    end
  end

  AST_STROBE_DECODE: assert property (@(posedge clk) disable iff (!resetn)
    !fdc_re_n_q |-> !fdc_cs_n_q && fdc_we_n_q) else $error("read strobe without select");
  AST_WAIT_ONLY_DATA: assert property (@(posedge clk) disable iff (!resetn)
    rd_st_q == R_WAIT |-> hit_data && ctrl_q.wait_en) else $error("wait on wrong port");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
    rd_st_q == R_WAIT && fdc_go |=> rd_st_q == R_STB ##STB_CYC din_en_q || !rd_cyc)
    else $error("wait not released");
  AST_DIN_INVERT: assert property (@(posedge clk) disable iff (!resetn)
    $past(rd_st_q) == R_STB && rd_st_q == R_HOLD |-> cpu_din_q == ~$past(fdc_d_i))
    else $error("data-in not inverted");
  AST_DIN_ONLY_READ: assert property (@(posedge clk) disable iff (!resetn)
    din_en_q |-> $past(rd_cyc)) else $error("data-in enabled outside read");
  AST_OUT_OE: assert property (@(posedge clk) disable iff (!resetn)
    fdc_d_oe_n_q == $past(rd_cyc && hit_board)) else $error("outbound enable wrong");
  AST_WR_INVERT: assert property (@(posedge clk) disable iff (!resetn)
    !fdc_we_n_q |-> fdc_d_o_q == ~$past(wr_out.d)) else $error("write byte not inverted");
  AST_CTRL_READ: assert property (@(posedge clk) disable iff (!resetn)
    rd_st_q == R_IDLE && rd_cyc && hit_ctrl |=> cpu_din_q == $past(ctrl_q))
    else $error("control readback wrong");
  AST_DRV_SEL: assert property (@(posedge clk) disable iff (!resetn)
    wr_new && hit_ctrl |-> ##2 drv_sel_q == $past(cpu_dout[3:0], 2))
    else $error("drive select not updated");
  AST_RESET_CTRL: assert property (@(posedge clk)
    !resetn |=> ctrl_q == fbp_ctrl_t'(`FBP_CTRL_RESET)) else $error("control not cleared");
  AST_WAIT_ENABLE: assert property (@(posedge clk) disable iff (!resetn)
    push && !ctrl_q.wait_en |=> !wr_hold_q || $past(wr_hold_q)) else $error("wait without enable");
endmodule

// [testbench/fbp_fdc_model.sv]
`timescale 1ns/10ps
module fbp_fdc_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // strobes and select from the glue
  input  wire logic       cs_n,
  input  wire logic       re_n,
  input  wire logic       we_n,
  input  wire logic [1:0] a,
  // internal bus, negative true
  input  wire logic [7:0] d_o,
  input  wire logic       d_oe_n,
  output logic [7:0]      d_i
);
  logic [7:0] regs [4];  // bus values as written
  logic [7:0] last_q;    // last level seen on the bus
  wire        rd_sel = !cs_n && !re_n;
  // released bus shows the inverse so a stale byte never passes
  assign d_i = rd_sel ? regs[a] : ~last_q;
  // four controller registers
  // latch bus byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_q <= 8'h00;
    end else begin
      if (!cs_n && !we_n && !d_oe_n) regs[a] <= d_o;
      last_q <= d_i;
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import fbp_pkg::*;
  // bus side
  logic       clk, resetn, sout, sinp, pwr_n, pdbin, int_en;
  logic [7:0] addr, cpu_dout, cpu_din_q, fdc_d_i, fdc_d_o_q, rv;
  logic       din_en_q, prdy_q, irq_q, fdc_d_oe_n_q, fdc_clk_q;
  // controller and drive side
  logic       fdc_cs_n_q, fdc_re_n_q, fdc_we_n_q, fdc_drq, fdc_busy;
  logic       fdc_intrq, fdc_early, fdc_late, fdc_dden_q, side_sel_q, size8_q;
  logic [1:0] fdc_a_q;
  logic [3:0] drv_sel_q;
  logic       rd_raw_n, sep_data_q, sep_clk_q, pre_early_q, pre_late_q;
  int         err_total, check_count;
  fbp_glue #(.STB_CYC(2), .HALF_CYC(2), .CELL_CYC(16)) i_fbp_glue (
    .clk, .resetn, .addr, .cpu_dout, .sout, .sinp, .pwr_n, .pdbin,
    .cpu_din_q, .din_en_q, .prdy_q, .irq_q, .int_en, .fdc_d_i, .fdc_d_o_q,
    .fdc_d_oe_n_q, .fdc_cs_n_q, .fdc_re_n_q, .fdc_we_n_q, .fdc_a_q,
    .fdc_drq, .fdc_busy, .fdc_intrq, .fdc_early, .fdc_late, .fdc_clk_q,
    .fdc_dden_q, .sep_data_q, .sep_clk_q, .pre_early_q, .pre_late_q,
    .drv_sel_q, .side_sel_q, .size8_q, .rd_raw_n);
  fbp_fdc_model i_fbp_fdc_model (
    .clk, .resetn, .cs_n(fdc_cs_n_q), .re_n(fdc_re_n_q), .we_n(fdc_we_n_q),
    .a(fdc_a_q), .d_o(fdc_d_o_q), .d_oe_n(fdc_d_oe_n_q), .d_i(fdc_d_i));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // a wait that ran out ends the run
  task automatic hang();
    err_total++;
    $display("MISMATCH wait exp done seen timeout");
    final_report();
  endtask
  task automatic wr_start(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    cpu_dout = d;
    sout = 1'b1;
    pwr_n = 1'b0;
  endtask
  // hold the cycle until ready, as a waited cpu would
  task automatic wr_end();
    repeat (2) @(negedge clk);
    for (int i = 0; prdy_q !== 1'b1; i++) begin
      if (i == 300) hang();
      @(negedge clk);
    end
    sout = 1'b0;
    pwr_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_start(a, d);
    wr_end();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    sinp = 1'b1;
    pdbin = 1'b1;
    for (int i = 0; din_en_q !== 1'b1; i++) begin
      if (i == 300) hang();
      @(negedge clk);
    end
    d = cpu_din_q;
    chk("rd ready", prdy_q, 8'h01);
    chk("oe_n in read", fdc_d_oe_n_q, 8'h01);
    sinp = 1'b0;
    pdbin = 1'b0;
    repeat (2) @(negedge clk);
    chk("din_en idle", din_en_q, 8'h00);
    chk("oe_n idle", fdc_d_oe_n_q, 8'h00);
  endtask
  // reset values, also after a reset in mid-run
  task automatic t_reset();
    chk("prdy rst", prdy_q, 8'h01);
    wr(8'h63, 8'h7f);
    @(negedge clk);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    chk("drv rst", drv_sel_q, 8'h00);
    rd(8'h63, rv);
    chk("ctrl rst", rv, 8'h00);
  endtask
  // drive select, side, size and density fields and their readback
  task automatic t_ctrl();
    logic [7:0] v [3] = '{8'h35, 8'h4a, 8'h5c};
    foreach (v[k]) begin
      wr(8'h63, v[k]);
      chk("drv_sel", drv_sel_q, {4'h0, v[k][3:0]});
      chk("side", side_sel_q, {7'h0, v[k][4]});
      chk("size8", size8_q, {7'h0, v[k][5]});
      chk("dden", fdc_dden_q, {7'h0, v[k][6]});
      rd(8'h63, rv);
      chk("ctrl rd", rv, v[k]);
    end
  endtask
  // controller ports, inverted both ways
  task automatic t_fdc();
    logic [7:0] v;
    wr(8'h63, 8'h00);
    for (int p = 0; p < 4; p++) begin
      v = 8'h3c ^ 8'(p * 8'h11);
      wr(8'h64 + 8'(p), v);
      chk("bus byte", i_fbp_fdc_model.regs[p], ~v);
      rd(8'h64 + 8'(p), rv);
      chk("fdc rd", rv, v);
    end
  endtask
  // foreign ports and unqualified strobes are ignored
  task automatic t_decode();
    wr(8'h62, 8'h0f);
    wr(8'h68, 8'h0f);
    chk("unmapped wr", drv_sel_q, 8'h00);
    @(negedge clk);
    addr = 8'h63;
    cpu_dout = 8'h0f;
    pwr_n = 1'b0;
    repeat (4) @(negedge clk);
    pwr_n = 1'b1;
    chk("no sout", drv_sel_q, 8'h00);
    addr = 8'h68;
    sinp = 1'b1;
    pdbin = 1'b1;
    repeat (6) @(negedge clk);
    chk("unmapped rd", din_en_q, 8'h00);
    sinp = 1'b0;
    pdbin = 1'b0;
    @(negedge clk);
  endtask
  // wait states only on the data port with the enable set
  task automatic t_wait();
    fdc_busy = 1'b1;
    wr(8'h63, 8'h80);
    wr_start(8'h65, 8'h11);
    repeat (2) @(negedge clk);
    chk("port 65 ready", prdy_q, 8'h01);
    wr_end();
    wr_start(8'h67, 8'h22);
    repeat (2) @(negedge clk);
    repeat (6) begin
      @(negedge clk);
      chk("prdy wait", prdy_q, 8'h00);
    end
    fdc_drq = 1'b1;
    wr_end();
    fdc_drq = 1'b0;
    wr_start(8'h67, 8'h33);
    repeat (4) @(negedge clk);
    chk("prdy busy", prdy_q, 8'h00);
    fdc_busy = 1'b0;
    wr_end();
    wr(8'h63, 8'h00);
    fdc_busy = 1'b1;
    wr_start(8'h67, 8'h44);
    repeat (4) @(negedge clk);
    chk("no wait", prdy_q, 8'h01);
    wr_end();
    fdc_busy = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  // sector read held until the controller asks for data
  task automatic t_rdwait();
    wr(8'h63, 8'h80);
    fdc_busy = 1'b1;
    @(negedge clk);
    addr = 8'h67;
    sinp = 1'b1;
    pdbin = 1'b1;
    repeat (6) @(negedge clk);
    chk("rd wait prdy", prdy_q, 8'h00);
    chk("rd wait din_en", din_en_q, 8'h00);
    fdc_drq = 1'b1;
    for (int i = 0; prdy_q !== 1'b1; i++) begin
      if (i == 300) hang();
      @(negedge clk);
    end
    chk("rd wait data", cpu_din_q, 8'h44);
    chk("rd wait din_en on", din_en_q, 8'h01);
    sinp = 1'b0;
    pdbin = 1'b0;
    fdc_drq = 1'b0;
    fdc_busy = 1'b0;
    repeat (2) @(negedge clk);
    wr(8'h63, 8'h00);
  endtask
  // separator: edge near cell start is clock, mid-cell edge is data
  task automatic t_sep();
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    rd_raw_n = 1'b0;
    @(negedge clk);
    rd_raw_n = 1'b1;
    chk("sep clk", {sep_clk_q, sep_data_q}, 8'h02);
    repeat (15) @(negedge clk);
    rd_raw_n = 1'b0;
    @(negedge clk);
    rd_raw_n = 1'b1;
    chk("sep data", {sep_clk_q, sep_data_q}, 8'h01);
  endtask
  // precompensation, interrupt option and controller clock
  task automatic t_misc();
    int n;
    fdc_early = 1'b1;
    repeat (2) @(negedge clk);
    chk("pre off", {pre_early_q, pre_late_q}, 8'h00);
    wr(8'h63, 8'h40);
    chk("pre early", {pre_early_q, pre_late_q}, 8'h02);
    fdc_early = 1'b0;
    fdc_late = 1'b1;
    repeat (2) @(negedge clk);
    chk("pre late", {pre_early_q, pre_late_q}, 8'h01);
    fdc_late = 1'b0;
    fdc_intrq = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq off", irq_q, 8'h00);
    int_en = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq on", irq_q, 8'h01);
    fdc_intrq = 1'b0;
    int_en = 1'b0;
    for (int i = 0; fdc_clk_q !== 1'b0; i++) begin
      if (i == 50) hang();
      @(negedge clk);
    end
    n = 0;
    while (fdc_clk_q !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    for (n = 0; fdc_clk_q !== 1'b0 && n < 50; n++) @(negedge clk);
    chk("clk half", 8'(n), 8'h02);
  endtask
  initial begin
    err_total = 0;
    check_count = 0;
    resetn = 1'b0;
    {sout, sinp, pdbin, int_en, fdc_drq, fdc_busy} = '0;
    {fdc_intrq, fdc_early, fdc_late} = '0;
    pwr_n = 1'b1;
    rd_raw_n = 1'b1;
    addr = 8'h00;
    cpu_dout = 8'h00;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_ctrl();
    t_fdc();
    t_decode();
    t_wait();
    t_rdwait();
    t_misc();
    t_sep();
    final_report();
  end
endmodule
